// file: cst_console_serial.sv
// Console serial terminal control with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "cst_params.svh"

module cst_console_serial
   import cst_pkg::*;
#(
   parameter int BIT_CYCLES  = `CST_BIT_CYCLES,
   parameter int TICK_CYCLES = `CST_TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        rx_line,
   output logic             tx_line,
   output logic             reader_run,
   output logic             irq
);

   // ========================================================================
   // Reset release and line synchroniser
   logic        rst_meta;
   logic        rst_n;
   logic        rx_meta;
   logic        rx_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Idle line is mark, so both stages come out of reset high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta <= 1'b1;
         rx_s    <= 1'b1;
      end else begin
         rx_meta <= rx_line;
         rx_s    <= rx_meta;
      end
   end

   // ========================================================================
   // Instruction decode helpers
   function automatic logic is_iot(input logic [11:0] code, input logic [5:0] dev);
      is_iot = (code[11:9] == `CST_IOT_OPCODE) && (code[8:3] == dev);
   endfunction

   // ========================================================================
   // Shared state
   cst_seq_t    seq;
   cst_cmd_t    cmd;
   cst_rx_t     rx_st;
   logic        key_flag;
   logic        print_flag;
   logic        int_enable;
   logic        skip_taken;
   logic        rx_armed;
   logic [11:0] working_register;
   logic [7:0]  receive_buffer;
   logic [7:0]  rx_shift;
   logic [2:0]  rx_bitn;
   logic [3:0]  rx_sub;
   logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
   logic        tick;
   logic [10:0] transmit_buffer;
   logic [3:0]  tx_left;
   logic [$clog2(BIT_CYCLES+1)-1:0] tx_timer;
   logic        tx_busy;

   // ========================================================================
   // AHB-Lite slave: address phase capture
   logic        dph_valid;
   logic        dph_write;
   logic [7:0]  dph_addr;
   logic        rd_done;
   logic        seq_busy;
   logic        wr_cmd;
   logic        wr_work;

   assign seq_busy = (seq != CST_SQ_IDLE);
   assign hresp    = 1'b0;
   // Stall while an instruction runs, and one cycle for each read to load hrdata
   assign hreadyout = !(dph_valid && (seq_busy || (!dph_write && !rd_done)));
   assign wr_cmd  = dph_valid && dph_write && hreadyout && (dph_addr == `CST_CMD_OFS);
   assign wr_work = dph_valid && dph_write && hreadyout && (dph_addr == `CST_WORK_OFS);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dph_valid <= 1'b0;
         dph_write <= 1'b0;
         dph_addr  <= 8'h00;
      end else if (hready) begin
         dph_valid <= hsel && htrans[1];
         dph_write <= hwrite;
         dph_addr  <= {haddr[7:2], 2'b00};
      end
   end

   // Read data is loaded once the sequencer is idle, so it never shows stale state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata  <= 32'h00000000;
         rd_done <= 1'b0;
      end else if (dph_valid && !dph_write && !rd_done && !seq_busy) begin
         rd_done <= 1'b1;
         unique case (dph_addr)
            `CST_CMD_OFS:    hrdata <= {19'h00000, cmd};
            `CST_WORK_OFS:   hrdata <= {20'h00000, working_register};
            `CST_STATUS_OFS: hrdata <= cst_status_t'{zero: 16'h0000,
                                          rx_char: receive_buffer, seq_busy: seq_busy,
                                          reader_run: reader_run, tx_busy: tx_busy,
                                          rx_armed: rx_armed, skip_taken: skip_taken,
                                          int_enable: int_enable, print_flag: print_flag,
                                          key_flag: key_flag};
            `CST_RXDATA_OFS: hrdata <= {24'h000000, receive_buffer};
            default:         hrdata <= 32'h00000000;
         endcase
      end else if (hreadyout) begin
         rd_done <= 1'b0;
      end
   end

   // ========================================================================
   // Instruction pulse sequencer: skip, then clear, then transfer
   logic kb_sel;
   logic pr_sel;
   logic skip_pulse;
   logic clear_pulse;
   logic transfer_pulse;
   logic kst_hit;
   logic sfe_hit;

   assign kb_sel         = !cmd.alt && is_iot(cmd.code, `CST_SEL_KEYBOARD);
   assign pr_sel         = !cmd.alt && is_iot(cmd.code, `CST_SEL_PRINTER);
   assign skip_pulse     = (seq == CST_SQ_P1) && cmd.code[0];
   assign clear_pulse    = (seq == CST_SQ_P2) && cmd.code[1];
   assign transfer_pulse = (seq == CST_SQ_P4) && cmd.code[2];
   // The I bit only adds its weight; both forms test the same flag
   assign kst_hit = cmd.alt && ((cmd.code & ~`CST_KST_IBIT) == `CST_KST_CODE)
                    && (seq == CST_SQ_P1);
   assign sfe_hit = cmd.alt && (cmd.code == `CST_SFE_CODE) && (seq == CST_SQ_P1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq <= CST_SQ_IDLE;
         cmd <= '0;
      end else begin
         unique case (seq)
            CST_SQ_IDLE: begin
               if (wr_cmd) begin
                  cmd <= cst_cmd_t'(hwdata[`CST_CMD_ALT_BIT:0]);
                  seq <= CST_SQ_P1;
               end
            end
            CST_SQ_P1: seq <= CST_SQ_P2;
            CST_SQ_P2: seq <= CST_SQ_P4;
            CST_SQ_P4: seq <= CST_SQ_IDLE;
         endcase
      end
   end

   // Skip result stands in place of advancing the instruction pointer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_taken <= 1'b0;
      end else if (wr_cmd) begin
         skip_taken <= 1'b0;
      end else if (skip_pulse && kb_sel && key_flag) begin
         skip_taken <= 1'b1;
      end else if (skip_pulse && pr_sel && print_flag) begin
         skip_taken <= 1'b1;
      end else if (kst_hit && key_flag) begin
         skip_taken <= 1'b1;
      end
   end

   // Interrupt enable follows the low working-register bit on the enable instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_enable <= 1'b0;
      end else if (sfe_hit) begin
         int_enable <= working_register[0];
      end
   end

   assign irq = int_enable && (key_flag || print_flag);

   // ========================================================================
   // Working register: software access plus clear and OR from the receiver
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         working_register <= `CST_WORK_RST;
      end else if (wr_work) begin
         working_register <= hwdata[11:0];
      end else if (clear_pulse && kb_sel) begin
         working_register <= 12'h000;
      end else if (transfer_pulse && kb_sel) begin
         working_register <= working_register | {4'h0, receive_buffer};
      end
   end

   // ========================================================================
   // Keyboard side flags; for key_flag a completing character wins over a same-cycle clear
   logic rx_start_ev;
   logic rx_done_ev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         key_flag <= 1'b0;
      end else if (rx_done_ev) begin
         key_flag <= 1'b1;
      end else if (clear_pulse && kb_sel) begin
         key_flag <= 1'b0;
      end
   end

   // Assembly is re-armed by the clearing pulse, held off once a character lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_armed <= 1'b1;
      end else if (clear_pulse && kb_sel) begin
         rx_armed <= 1'b1;
      end else if (rx_done_ev) begin
         rx_armed <= 1'b0;
      end
   end

   // Reader relay drops as a character begins; a clearing pulse lets tape advance
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reader_run <= 1'b0;
      end else if (clear_pulse && kb_sel) begin
         reader_run <= 1'b1;
      end else if (rx_start_ev) begin
         reader_run <= 1'b0;
      end
   end

   // ========================================================================
   // Receiver: sixteen ticks per bit, start checked at mid-bit
   assign tick        = (tick_cnt == '0);
   assign rx_start_ev = (rx_st == CST_RX_IDLE) && rx_armed && !rx_s;
   assign rx_done_ev  = (rx_st == CST_RX_STOP) && tick && (rx_sub == `CST_RX_END_TICK);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= ($bits(tick_cnt))'(TICK_CYCLES - 1);
      end else begin
         tick_cnt <= tick_cnt - 1'b1;
      end
   end

   // A free running tick gives at most one sixteenth of a bit of phase error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st    <= CST_RX_IDLE;
         rx_sub   <= 4'h0;
         rx_bitn  <= 3'h0;
         rx_shift <= 8'h00;
      end else begin
         unique case (rx_st)
            CST_RX_IDLE: begin
               if (rx_start_ev) begin
                  rx_st  <= CST_RX_START;
                  rx_sub <= 4'h0;
               end
            end
            CST_RX_START: begin
               if (tick) begin
                  rx_sub <= rx_sub + 4'h1;
                  if (rx_sub == `CST_RX_MID_TICK) begin
                     rx_sub  <= 4'h0;
                     rx_bitn <= 3'h0;
                     rx_st   <= rx_s ? CST_RX_IDLE : CST_RX_DATA;
                  end
               end
            end
            CST_RX_DATA: begin
               if (tick) begin
                  rx_sub <= rx_sub + 4'h1;
                  if (rx_sub == `CST_RX_END_TICK) begin
                     rx_shift <= {rx_s, rx_shift[7:1]};
                     rx_bitn  <= rx_bitn + 3'h1;
                     if (rx_bitn == 3'h7) begin
                        rx_st <= CST_RX_STOP;
                     end
                  end
               end
            end
            CST_RX_STOP: begin
               if (tick) begin
                  rx_sub <= rx_sub + 4'h1;
                  if (rx_sub == `CST_RX_END_TICK) begin
                     rx_st <= CST_RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Last complete character is held until the next one lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         receive_buffer <= 8'h00;
      end else if (rx_done_ev) begin
         receive_buffer <= rx_shift;
      end
   end

   // ========================================================================
   // Transmitter: eleven-unit frame, line idles at mark
   logic tx_load;
   logic tx_bit_end;
   logic tx_done_ev;

   assign tx_load    = transfer_pulse && pr_sel;
   assign tx_busy    = (tx_left != 4'h0);
   assign tx_bit_end = tx_busy && (tx_timer == '0);
   assign tx_done_ev = tx_bit_end && (tx_left == 4'h1);
   assign tx_line    = transmit_buffer[0];

   // Loading while busy restarts the frame; software must wait for the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         transmit_buffer <= 11'h7FF;
         tx_left         <= 4'h0;
         tx_timer        <= '0;
      end else if (tx_load) begin
         transmit_buffer <= {2'b11, working_register[7:0], 1'b0};
         tx_left         <= `CST_TX_FRAME_BITS;
         tx_timer        <= ($bits(tx_timer))'(BIT_CYCLES - 1);
      end else if (tx_bit_end) begin
         transmit_buffer <= {1'b1, transmit_buffer[10:1]};
         tx_left         <= tx_left - 4'h1;
         tx_timer        <= ($bits(tx_timer))'(BIT_CYCLES - 1);
      end else if (tx_busy) begin
         tx_timer <= tx_timer - 1'b1;
      end
   end

   // Printer flag: end of frame wins over a same-cycle clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         print_flag <= 1'b0;
      end else if (tx_done_ev) begin
         print_flag <= 1'b1;
      end else if (clear_pulse && pr_sel) begin
         print_flag <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: cst_console_serial_properties.sv
// Port-level assertions for the console serial terminal control
`timescale 1ns/1ps
`default_nettype none
module cst_console_props #(
   parameter int BIT_CYCLES  = 160,
   parameter int TICK_CYCLES = 10
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rx_line,
   input wire logic        tx_line,
   input wire logic        reader_run,
   input wire logic        irq
);
   int   run_cnt;
   int   since_cmd;
   logic prev_tx;
   logic acc;

   // ========================================================================
   // Helper counters
   assign acc = hsel && htrans[1] && hready;

   // Length of the current printer line run; a frame must only change on bit edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_tx <= 1'b1;
         run_cnt <= 0;
      end else begin
         prev_tx <= tx_line;
         run_cnt <= (tx_line != prev_tx) ? 1 : run_cnt + 1;
      end
   end

   // Cycles since the last instruction write; saturates so it never wraps
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) since_cmd <= 255;
      else if (acc && hwrite && haddr[7:2] == 6'h00) since_cmd <= 0;
      else if (since_cmd < 255) since_cmd <= since_cmd + 1;
   end

   // ========================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response not OKAY");
   a_read_waits: assert property (acc && !hwrite |=> !hreadyout)
      else $error("read data phase did not wait");
   a_rise_on_edge: assert property ($rose(tx_line) |-> run_cnt % BIT_CYCLES == 0)
      else $error("space run not a whole number of bits");
   a_fall_on_edge: assert property ($fell(tx_line) |-> since_cmd <= 8 || run_cnt % BIT_CYCLES == 0)
      else $error("line fell off a bit edge without a load");
   a_space_bound: assert property (!tx_line && !prev_tx |-> run_cnt <= 9 * BIT_CYCLES)
      else $error("space run longer than start plus eight bits");
   a_reader_stops: assert property ($fell(rx_line) && reader_run |-> ##[1:120] !reader_run)
      else $error("reader relay not dropped at character start");
   a_reader_cause: assert property ($rose(reader_run) |-> since_cmd <= 8)
      else $error("reader released without an instruction");
   a_irq_clear: assert property ($fell(irq) |-> since_cmd <= 8)
      else $error("interrupt dropped without an instruction");

   c_irq: cover property ($rose(irq));
   c_reader: cover property ($fell(reader_run));
   c_frame: cover property ($fell(tx_line));
endmodule

bind cst_console_serial cst_console_props #(.BIT_CYCLES(BIT_CYCLES), .TICK_CYCLES(TICK_CYCLES))
   u_props (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .rx_line(rx_line), .tx_line(tx_line), .reader_run(reader_run), .irq(irq));
`default_nettype wire

// file: cst_params.svh
// Constants of the console serial terminal control: offsets, fields, timing and codes
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// ===========================================================================
// Register byte offsets on the AHB-Lite slave, working register reset value and instruction alt bit position
`define CST_CMD_OFS        8'h00
`define CST_WORK_OFS       8'h04
`define CST_STATUS_OFS     8'h08
`define CST_RXDATA_OFS     8'h0C
`define CST_WORK_RST       12'h000
`define CST_CMD_ALT_BIT    12

// ===========================================================================
// Instruction word layout and codes
`define CST_IOT_OPCODE     3'h6
`define CST_SEL_KEYBOARD   6'h03
`define CST_SEL_PRINTER    6'h04
`define CST_KST_CODE       12'h10D
`define CST_KST_IBIT       12'h010
`define CST_SFE_CODE       12'h004

// ===========================================================================
// Timing: clock rate, line rate, and derived counts
`define CST_CLK_HZ         20000000
`define CST_LINE_BAUD      110
`define CST_FRAME_MS       100
`define CST_OVERSAMPLE     16
`define CST_BIT_CYCLES     (`CST_CLK_HZ / `CST_LINE_BAUD)
`define CST_TICK_CYCLES    (`CST_BIT_CYCLES / `CST_OVERSAMPLE)
`define CST_TX_FRAME_BITS  4'hB
`define CST_RX_MID_TICK    4'h7
`define CST_RX_END_TICK    4'hF

`endif

// file: cst_pkg.sv
// Types shared by the console serial terminal control
`include "cst_params.svh"
package cst_pkg;

   // ========================================================================
   // Pulse sequencer for one I/O instruction
   typedef enum logic [1:0] {
      CST_SQ_IDLE = 2'b00,
      CST_SQ_P1   = 2'b01,
      CST_SQ_P2   = 2'b10,
      CST_SQ_P4   = 2'b11
   } cst_seq_t;

   // ========================================================================
   // Receiver states
   typedef enum logic [1:0] {
      CST_RX_IDLE  = 2'b00,
      CST_RX_START = 2'b01,
      CST_RX_DATA  = 2'b10,
      CST_RX_STOP  = 2'b11
   } cst_rx_t;

   // ========================================================================
   // Status word as read over the bus
   typedef struct packed {
      logic [15:0] zero;
      logic [7:0]  rx_char;
      logic        seq_busy;
      logic        reader_run;
      logic        tx_busy;
      logic        rx_armed;
      logic        skip_taken;
      logic        int_enable;
      logic        print_flag;
      logic        key_flag;
   } cst_status_t;

   // ========================================================================
   // Latched instruction
   typedef struct packed {
      logic        alt;
      logic [11:0] code;
   } cst_cmd_t;

endpackage

// file: cst_terminal_model.sv
// Behavioural current-loop terminal: keyboard sender and printer decoder
`timescale 1ns/1ps
`default_nettype none
module cst_terminal_model #(
   parameter int BIT_CYCLES = 160
) (
   input  wire logic clk,
   input  wire logic tx_line,
   output var logic  rx_line
);
   logic [7:0] last_char = 8'h00;
   int         n_bad = 0;

   // Loop current idles at mark between characters
   initial rx_line = 1'b1;

   // Keyboard: start space, eight bits low first, two stop marks
   task automatic send_char(input logic [7:0] c);
      logic [10:0] f;
      f = {2'b11, c, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         rx_line <= f[i];
         repeat (BIT_CYCLES - 1) @(posedge clk);
      end
   endtask

   // Printer: sample at bit centres, so a wrong rate shows up as wrong bits
   initial begin
      logic [7:0] c;
      forever begin
         @(negedge tx_line);
         repeat (BIT_CYCLES / 2) @(posedge clk);
         if (tx_line !== 1'b0) n_bad++;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            c[i] = tx_line;
         end
         repeat (BIT_CYCLES) @(posedge clk);
         if (tx_line !== 1'b1) n_bad++;
         repeat (BIT_CYCLES) @(posedge clk);
         if (tx_line !== 1'b1) n_bad++;
         last_char = c;
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the console serial terminal control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cst_pkg::*;
   localparam int BIT = 160;
   logic        clk, nrst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        rx_line, tx_line, reader_run, irq;
   int          n_fail = 0;
   int          tests_run = 0;

   cst_console_serial #(.BIT_CYCLES(BIT), .TICK_CYCLES(10)) dut (.clk(clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rx_line(rx_line), .tx_line(tx_line), .reader_run(reader_run),
      .irq(irq));
   cst_terminal_model #(.BIT_CYCLES(BIT)) term (.clk(clk), .tx_line(tx_line),
      .rx_line(rx_line));

   // ========================================================================
   // Clock, verdict and shared tasks
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask

   // Single transfer; no latency assumed, only hready ends each phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   // Instruction then a status read, which waits out the pulse sequence
   task automatic io_transfer_instruction(input logic [12:0] code);
      xfer(1'b1, 8'h00, {19'h0, code});
      xfer(1'b0, 8'h08, 32'h0);
   endtask

   task automatic skip_is(input logic [12:0] code, input logic exp, input string nm);
      io_transfer_instruction(code);
      chk(nm, {31'h0, exp}, {31'h0, rd[3]});
   endtask

   task automatic poll_print();
      rd = 32'h0;
      for (int i = 0; i < 1000 && rd[1] !== 1'b1; i++) xfer(1'b0, 8'h08, 32'h0);
   endtask

   // ========================================================================
   // Scenarios
   task automatic t_reset();
      chk("tx idle", 32'h1, {31'h0, tx_line});
      xfer(1'b0, 8'h08, 32'h0);
      chk("status", 32'h10, {24'h0, rd[7:0]});
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      xfer(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      xfer(1'b1, 8'h04, 32'hFFFF_FABC);
      xfer(1'b0, 8'h04, 32'h0);
      chk("work", 32'hABC, rd);
   endtask

   task automatic t_receive();
      xfer(1'b1, 8'h04, 32'hFFF);
      io_transfer_instruction(13'h0C1A);
      xfer(1'b0, 8'h04, 32'h0);
      chk("work cleared", 32'h0, rd);
      chk("reader on", 32'h1, {31'h0, reader_run});
      skip_is(13'h0C19, 1'b0, "key skip idle");
      term.send_char(8'hA5);
      chk("reader held", 32'h0, {31'h0, reader_run});
      skip_is(13'h0C19, 1'b1, "key skip");
      skip_is(13'h0C29, 1'b0, "other device");
      skip_is(13'h0C21, 1'b0, "print skip");
      skip_is(13'h110D, 1'b1, "key struck");
      skip_is(13'h111D, 1'b1, "key struck i");
      xfer(1'b0, 8'h0C, 32'h0);
      chk("rx char", 32'hA5, rd);
      xfer(1'b1, 8'h04, 32'h300);
      io_transfer_instruction(13'h0C1C);
      xfer(1'b0, 8'h04, 32'h0);
      chk("static read", 32'h3A5, rd);
      skip_is(13'h0C19, 1'b1, "flag kept");
      xfer(1'b1, 8'h04, 32'hF00);
      io_transfer_instruction(13'h0C1E);
      xfer(1'b0, 8'h04, 32'h0);
      chk("dynamic read", 32'h0A5, rd);
      chk("reader again", 32'h1, {31'h0, reader_run});
      skip_is(13'h0C19, 1'b0, "flag cleared");
      term.send_char(8'h3C);
      xfer(1'b0, 8'h08, 32'h0);
      chk("second char", 32'h3C01, {16'h0, rd[15:8], 7'h0, rd[0]});
   endtask

   // First load alone, second combined with the clear while the flag is set
   task automatic t_transmit();
      xfer(1'b1, 8'h04, 32'h15A);
      io_transfer_instruction(13'h0C24);
      chk("tx busy", 32'h1, {31'h0, rd[5]});
      poll_print();
      chk("print flag", 32'h1, {31'h0, rd[1]});
      chk("printed", 32'h5A, {24'h0, term.last_char});
      skip_is(13'h0C21, 1'b1, "print skip");
      xfer(1'b1, 8'h04, 32'hEC3);
      io_transfer_instruction(13'h0C26);
      chk("flag in frame", 32'h0, {31'h0, rd[1]});
      poll_print();
      chk("loaded", 32'hC3, {24'h0, term.last_char});
      io_transfer_instruction(13'h0C22);
      chk("print cleared", 32'h0, {31'h0, rd[1]});
      chk("frame errors", 32'h0, term.n_bad);
   endtask

   task automatic t_irq();
      xfer(1'b1, 8'h04, 32'h1);
      io_transfer_instruction(13'h1004);
      chk("irq on", 32'h1, {31'h0, irq});
      io_transfer_instruction(13'h0C22);
      chk("irq key", 32'h1, {31'h0, irq});
      io_transfer_instruction(13'h0C1A);
      chk("irq off", 32'h0, {31'h0, irq});
      skip_is(13'h110D, 1'b0, "key struck idle");
      io_transfer_instruction(13'h1004);
      io_transfer_instruction(13'h0C24);
      poll_print();
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("zero char", 32'h0, {24'h0, term.last_char});
   endtask

   // Reset, then scenarios in order; held low five cycles
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      hsel <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_receive();
      t_transmit();
      t_irq();
      results();
   end

   // Watchdog: about four times the expected run
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
